// File: design/ddrdv_pkg.sv
package ddrdv_pkg;
	// ==========================================
	// pin widths
	localparam int ROW_W  = 13;
	localparam int COL_W  = 10;
	localparam int BANK_W = 2;
	localparam int DQ_W   = 8;
	localparam int NBANK  = 4;
	localparam int AP_BIT = 10;
	// ==========================================
	// mode word layout and codes
	localparam int         MODE_W     = 7;
	localparam int         BL_LSB     = 0;
	localparam int         ORD_BIT    = 3;
	localparam int         CL_LSB     = 4;
	localparam logic [6:0] MODE_RST   = 7'h22;
	localparam logic [2:0] BL_CODE_4  = 3'h2;
	localparam logic [2:0] BL_CODE_8  = 3'h3;
	localparam logic [2:0] CL_CODE_25 = 3'h6;
	localparam logic [2:0] CL_CODE_3  = 3'h3;
	localparam logic [3:0] BEATS_2    = 4'h2;
	localparam logic [3:0] BEATS_4    = 4'h4;
	localparam logic [3:0] BEATS_8    = 4'h8;
	localparam logic [2:0] HALVES_2   = 3'h4;
	localparam logic [2:0] HALVES_25  = 3'h5;
	localparam logic [2:0] HALVES_3   = 3'h6;
	localparam logic [1:0] BA_MODE    = 2'h0;
	// ==========================================
	// commands as {ras_n, cas_n, we_n}
	localparam logic [2:0] CMD_MRS = 3'h0;
	localparam logic [2:0] CMD_REF = 3'h1;
	localparam logic [2:0] CMD_PRE = 3'h2;
	localparam logic [2:0] CMD_ACT = 3'h3;
	localparam logic [2:0] CMD_WR  = 3'h4;
	localparam logic [2:0] CMD_RD  = 3'h5;
	localparam logic [2:0] CMD_BST = 3'h6;
	// ==========================================
	// register map
	localparam int         APB_AW     = 8;
	localparam logic [7:0] OFS_MODE   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_REFCNT = 8'h08;
	localparam int         STS_PWR    = 4;
	localparam int         STS_BUSY   = 6;
	localparam int         REFCNT_W   = 16;
	// ==========================================
	// types
	typedef logic [COL_W-1:0] ddrdv_col_type;
	typedef enum logic [1:0] {PWR_ACTIVE, PWR_PDN_PRE, PWR_PDN_ACT, PWR_SELF_REF} ddrdv_pwr_type;
	typedef enum logic [2:0] {DP_IDLE, DP_RWAIT, DP_READ, DP_POST, DP_WRITE} ddrdv_dp_type;
endpackage

// File: design/ddrdv_pins_if.sv
`timescale 1ns/10ps
interface ddrdv_pins_if;
	logic                         ck_rise;
	logic                         ck_fall;
	logic                         dqs_rise;
	logic                         dqs_fall;
	logic                         cke;
	logic                         cs_n;
	logic [2:0]                   cmd;
	logic [ddrdv_pkg::BANK_W-1:0] bank;
	logic [ddrdv_pkg::ROW_W-1:0]  addr;
	logic                         dm;
	logic [ddrdv_pkg::DQ_W-1:0]   dq;
	modport sync (output ck_rise, ck_fall, dqs_rise, dqs_fall, cke, cs_n, cmd, bank, addr, dm, dq);
	modport core (input ck_rise, ck_fall, dqs_rise, dqs_fall, cke, cs_n, cmd, bank, addr, dm, dq);
endinterface

// File: design/ddrdv_pin_sync.sv
`timescale 1ns/10ps
module ddrdv_pin_sync (
	// clock and reset
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	// raw pins
	input  wire logic                         ck,
	input  wire logic                         ck_n,
	input  wire logic                         dqs,
	input  wire logic                         cke,
	input  wire logic                         cs_n,
	input  wire logic                         ras_n,
	input  wire logic                         cas_n,
	input  wire logic                         we_n,
	input  wire logic                         dm,
	input  wire logic [ddrdv_pkg::BANK_W-1:0] bank_select_lines,
	input  wire logic [ddrdv_pkg::ROW_W-1:0]  addr,
	input  wire logic [ddrdv_pkg::DQ_W-1:0]   dq,
	// synchronised view
	ddrdv_pins_if.sync                        pins
);
	// =====================================
	// two stages, then a third for edges
	localparam int W = 32;
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s1_nxt;
	logic [W-1:0] s2_nxt;
	logic         xing_r;
	logic         xing_nxt;
	logic         dqs_r;
	logic         dqs_nxt;
	logic         xing;

	always_comb begin
		s1_nxt   = {ck, ck_n, dqs, cke, cs_n, ras_n, cas_n, we_n, dm, bank_select_lines, addr, dq};
		s2_nxt   = s1_r;
		// crossing: true high and complement low, taken together
		xing     = s2_r[31] && !s2_r[30];
		xing_nxt = xing;
		dqs_nxt  = s2_r[29];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r   <= '0;
			s2_r   <= '0;
			xing_r <= 1'b0;
			dqs_r  <= 1'b0;
		end else begin
			s1_r   <= s1_nxt;
			s2_r   <= s2_nxt;
			xing_r <= xing_nxt;
			dqs_r  <= dqs_nxt;
		end
	end

	assign pins.ck_rise  = xing && !xing_r;
	assign pins.ck_fall  = !xing && xing_r;
	assign pins.dqs_rise = s2_r[29] && !dqs_r;
	assign pins.dqs_fall = !s2_r[29] && dqs_r;
	assign pins.cke      = s2_r[28];
	assign pins.cs_n     = s2_r[27];
	assign pins.cmd      = s2_r[26:24];
	assign pins.dm       = s2_r[23];
	assign pins.bank     = s2_r[22:21];
	assign pins.addr     = s2_r[20:8];
	assign pins.dq       = s2_r[7:0];
endmodule

// File: design/ddrdv_top.sv
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
// Notes on behaviour
// - commands taken at true clock rising crossing
// - data, mask, strobe not tied to command edge
// - chip select high ignores new commands only
// - command from ras, cas, we with cs
// - thirteen row bits, ten column, a10 autoprecharge
// - bank lines pick bank for row, column
// - eight data lines move on strobe edges
// - strobe driven here only during reads
// - read strobe edge-aligned, write strobe centred
// - mask high drops that write beat
// - clock enable low enters power-down states
// - two data words per clock cycle
// - read latency 2, 2.5 or 3
// - burst length 2, 4 or 8
// - mode selects length, latency, burst order
// - auto, self refresh; precharged, active power-down
// - four banks of byte-wide words
// - activate is ras low, cas, we high
// - precharge with a10 high closes all banks
module ddrdv_top #(
	parameter int ROW_KEEP = 2,
	parameter int COL_KEEP = 3
) (
	// apb slave
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic [ddrdv_pkg::APB_AW-1:0] paddr,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [31:0]                  pwdata,
	output      logic [31:0]                  prdata,
	output      logic                         pready,
	output      logic                         pslverr,
	// command and address pins
	input  wire logic                         ck,
	input  wire logic                         ck_n,
	input  wire logic                         cke,
	input  wire logic                         cs_n,
	input  wire logic                         ras_n,
	input  wire logic                         cas_n,
	input  wire logic                         we_n,
	input  wire logic [ddrdv_pkg::BANK_W-1:0] bank_select_lines,
	input  wire logic [ddrdv_pkg::ROW_W-1:0]  addr,
	// data pins
	input  wire logic                         dm,
	input  wire logic [ddrdv_pkg::DQ_W-1:0]   dq_in,
	output      logic [ddrdv_pkg::DQ_W-1:0]   dq_out,
	output      logic                         dq_oe,
	input  wire logic                         dqs_in,
	output      logic                         dqs_out,
	output      logic                         dqs_oe
);
	// =====================================
	// storage kept: bank, low row bits, low column bits
	localparam int IDX_W = ddrdv_pkg::BANK_W + ROW_KEEP + COL_KEEP;
	localparam int DEPTH = 1 << IDX_W;

	ddrdv_pins_if pins ();

	ddrdv_pin_sync u_sync (
		.pclk              (pclk),
		.presetn           (presetn),
		.ck                (ck),
		.ck_n              (ck_n),
		.dqs               (dqs_in),
		.cke               (cke),
		.cs_n              (cs_n),
		.ras_n             (ras_n),
		.cas_n             (cas_n),
		.we_n              (we_n),
		.dm                (dm),
		.bank_select_lines (bank_select_lines),
		.addr              (addr),
		.dq                (dq_in),
		.pins              (pins)
	);

	// =====================================
	// helpers
	function automatic logic [3:0] bl_beats(input logic [2:0] code);
		case (code)
			ddrdv_pkg::BL_CODE_4: return ddrdv_pkg::BEATS_4;
			ddrdv_pkg::BL_CODE_8: return ddrdv_pkg::BEATS_8;
			default: return ddrdv_pkg::BEATS_2;
		endcase
	endfunction

	function automatic logic [2:0] cl_halves(input logic [2:0] code);
		case (code)
			ddrdv_pkg::CL_CODE_25: return ddrdv_pkg::HALVES_25;
			ddrdv_pkg::CL_CODE_3: return ddrdv_pkg::HALVES_3;
			default: return ddrdv_pkg::HALVES_2;
		endcase
	endfunction

	// wrap inside the burst-aligned block, sequential or interleaved
	function automatic ddrdv_pkg::ddrdv_col_type burst_col(input ddrdv_pkg::ddrdv_col_type base,
		input logic [3:0] beat, input logic [3:0] bl, input logic inter);
		ddrdv_pkg::ddrdv_col_type mask;
		ddrdv_pkg::ddrdv_col_type step;
		mask = ddrdv_pkg::ddrdv_col_type'(bl - 4'h1);
		step = inter ? (base ^ ddrdv_pkg::ddrdv_col_type'(beat)) : (base + ddrdv_pkg::ddrdv_col_type'(beat));
		return (base & ~mask) | (step & mask);
	endfunction

	// =====================================
	// core state
	ddrdv_pkg::ddrdv_pwr_type         pwr_r;
	ddrdv_pkg::ddrdv_pwr_type         pwr_nxt;
	ddrdv_pkg::ddrdv_dp_type          dp_r;
	ddrdv_pkg::ddrdv_dp_type          dp_nxt;
	logic [ddrdv_pkg::MODE_W-1:0]     mode_r;
	logic [ddrdv_pkg::MODE_W-1:0]     mode_nxt;
	logic [ddrdv_pkg::NBANK-1:0]      open_r;
	logic [ddrdv_pkg::NBANK-1:0]      open_nxt;
	logic [ROW_KEEP-1:0]              row_r [ddrdv_pkg::NBANK];
	logic [ROW_KEEP-1:0]              row_nxt [ddrdv_pkg::NBANK];
	logic [ddrdv_pkg::BANK_W-1:0]     bbank_r;
	logic [ddrdv_pkg::BANK_W-1:0]     bbank_nxt;
	ddrdv_pkg::ddrdv_col_type         bcol_r;
	ddrdv_pkg::ddrdv_col_type         bcol_nxt;
	logic                             ap_r;
	logic                             ap_nxt;
	logic [3:0]                       beat_r;
	logic [3:0]                       beat_nxt;
	logic [2:0]                       wait_r;
	logic [2:0]                       wait_nxt;
	logic [ddrdv_pkg::DQ_W-1:0]       mem_r [DEPTH];
	logic [ddrdv_pkg::DQ_W-1:0]       mem_nxt [DEPTH];
	logic [ddrdv_pkg::REFCNT_W-1:0]   refcnt_r;
	logic [ddrdv_pkg::REFCNT_W-1:0]   refcnt_nxt;
	logic [ddrdv_pkg::DQ_W-1:0]       dq_out_r;
	logic [ddrdv_pkg::DQ_W-1:0]       dq_out_nxt;
	logic                             dq_oe_r;
	logic                             dq_oe_nxt;
	logic                             dqs_out_r;
	logic                             dqs_out_nxt;
	logic                             dqs_oe_r;
	logic                             dqs_oe_nxt;
	// apb state
	logic [31:0]                      prdata_r;
	logic [31:0]                      prdata_nxt;
	logic                             pready_r;
	logic                             pready_nxt;
	logic                             pslverr_r;
	logic                             pslverr_nxt;

	logic                             half;
	logic                             cmd_take;
	logic [3:0]                       bl;
	logic [IDX_W-1:0]                 cur_idx;
	ddrdv_pkg::ddrdv_col_type         cur_col;
	logic                             apb_fire;

	assign half     = pins.ck_rise || pins.ck_fall;
	// decoder runs only while selected and not powered down
	assign cmd_take = pins.ck_rise && !pins.cs_n && pins.cke && (pwr_r == ddrdv_pkg::PWR_ACTIVE);
	assign bl       = bl_beats(mode_r[ddrdv_pkg::BL_LSB +: 3]);
	assign cur_col  = burst_col(bcol_r, beat_r, bl, mode_r[ddrdv_pkg::ORD_BIT]);
	assign cur_idx  = {bbank_r, row_r[bbank_r], cur_col[COL_KEEP-1:0]};
	assign apb_fire = psel && penable && pready_r;

	// =====================================
	// command decoder, power state, data path
	always_comb begin
		pwr_nxt     = pwr_r;
		dp_nxt      = dp_r;
		mode_nxt    = mode_r;
		open_nxt    = open_r;
		row_nxt     = row_r;
		bbank_nxt   = bbank_r;
		bcol_nxt    = bcol_r;
		ap_nxt      = ap_r;
		beat_nxt    = beat_r;
		wait_nxt    = wait_r;
		mem_nxt     = mem_r;
		refcnt_nxt  = refcnt_r;
		dq_out_nxt  = dq_out_r;
		dq_oe_nxt   = dq_oe_r;
		dqs_out_nxt = dqs_out_r;
		dqs_oe_nxt  = dqs_oe_r;

		// clock enable is looked at on each rising crossing
		if (pins.ck_rise) begin
			if (pwr_r != ddrdv_pkg::PWR_ACTIVE) begin
				if (pins.cke) begin
					pwr_nxt = ddrdv_pkg::PWR_ACTIVE;
				end
			end else if (!pins.cke) begin
				if (!pins.cs_n && pins.cmd == ddrdv_pkg::CMD_REF) begin
					pwr_nxt    = ddrdv_pkg::PWR_SELF_REF;
					refcnt_nxt = refcnt_r + 1'b1;
				end else if (|open_r) begin
					pwr_nxt = ddrdv_pkg::PWR_PDN_ACT;
				end else begin
					pwr_nxt = ddrdv_pkg::PWR_PDN_PRE;
				end
			end
		end

		case (dp_r)
			ddrdv_pkg::DP_RWAIT: begin
				if (half) begin
					if (wait_r == 3'h1) begin
						dp_nxt      = ddrdv_pkg::DP_READ;
						dq_out_nxt  = mem_r[cur_idx];
						dq_oe_nxt   = 1'b1;
						dqs_out_nxt = 1'b1;
						beat_nxt    = beat_r + 4'h1;
					end else begin
						wait_nxt = wait_r - 3'h1;
						if (wait_r == 3'h2) begin
							dqs_oe_nxt  = 1'b1;
							dqs_out_nxt = 1'b0;
						end
					end
				end
			end
			ddrdv_pkg::DP_READ: begin
				if (half) begin
					if (beat_r == bl) begin
						dp_nxt    = ddrdv_pkg::DP_POST;
						dq_oe_nxt = 1'b0;
					end else begin
						dq_out_nxt  = mem_r[cur_idx];
						dqs_out_nxt = !dqs_out_r;
						beat_nxt    = beat_r + 4'h1;
					end
				end
			end
			ddrdv_pkg::DP_POST: begin
				if (half) begin
					dp_nxt      = ddrdv_pkg::DP_IDLE;
					dqs_oe_nxt  = 1'b0;
					dqs_out_nxt = 1'b0;
					if (ap_r) begin
						open_nxt[bbank_r] = 1'b0;
					end
				end
			end
			ddrdv_pkg::DP_WRITE: begin
				// write beats follow the host strobe, not the clock
				if (pins.dqs_rise || pins.dqs_fall) begin
					if (!pins.dm) begin
						mem_nxt[cur_idx] = pins.dq;
					end
					beat_nxt = beat_r + 4'h1;
					if (beat_r + 4'h1 == bl) begin
						dp_nxt = ddrdv_pkg::DP_IDLE;
						if (ap_r) begin
							open_nxt[bbank_r] = 1'b0;
						end
					end
				end
			end
			default: ;
		endcase

		// a new column command takes over any burst in progress
		if (cmd_take) begin
			case (pins.cmd)
				ddrdv_pkg::CMD_ACT: begin
					open_nxt[pins.bank] = 1'b1;
					row_nxt[pins.bank]  = pins.addr[ROW_KEEP-1:0];
				end
				ddrdv_pkg::CMD_PRE: begin
					if (pins.addr[ddrdv_pkg::AP_BIT]) begin
						open_nxt = '0;
					end else begin
						open_nxt[pins.bank] = 1'b0;
					end
				end
				ddrdv_pkg::CMD_REF: begin
					refcnt_nxt = refcnt_r + 1'b1;
				end
				ddrdv_pkg::CMD_MRS: begin
					if (pins.bank == ddrdv_pkg::BA_MODE) begin
						mode_nxt = pins.addr[ddrdv_pkg::MODE_W-1:0];
					end
				end
				ddrdv_pkg::CMD_RD, ddrdv_pkg::CMD_WR: begin
					bbank_nxt = pins.bank;
					bcol_nxt  = pins.addr[ddrdv_pkg::COL_W-1:0];
					ap_nxt    = pins.addr[ddrdv_pkg::AP_BIT];
					beat_nxt  = 4'h0;
					dq_oe_nxt = 1'b0;
					if (pins.cmd == ddrdv_pkg::CMD_RD) begin
						dp_nxt   = ddrdv_pkg::DP_RWAIT;
						wait_nxt = cl_halves(mode_r[ddrdv_pkg::CL_LSB +: 3]);
					end else begin
						dp_nxt      = ddrdv_pkg::DP_WRITE;
						dqs_oe_nxt  = 1'b0;
						dqs_out_nxt = 1'b0;
					end
				end
				ddrdv_pkg::CMD_BST: begin
					if (dp_r == ddrdv_pkg::DP_READ || dp_r == ddrdv_pkg::DP_RWAIT) begin
						dp_nxt    = ddrdv_pkg::DP_POST;
						dq_oe_nxt = 1'b0;
					end
				end
				default: ;
			endcase
		end

		if (apb_fire && pwrite && paddr == ddrdv_pkg::OFS_MODE) begin
			mode_nxt = pwdata[ddrdv_pkg::MODE_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwr_r     <= ddrdv_pkg::PWR_ACTIVE;
			dp_r      <= ddrdv_pkg::DP_IDLE;
			mode_r    <= ddrdv_pkg::MODE_RST;
			open_r    <= '0;
			row_r     <= '{default: '0};
			bbank_r   <= '0;
			bcol_r    <= '0;
			ap_r      <= 1'b0;
			beat_r    <= 4'h0;
			wait_r    <= 3'h0;
			mem_r     <= '{default: '0};
			refcnt_r  <= '0;
			dq_out_r  <= '0;
			dq_oe_r   <= 1'b0;
			dqs_out_r <= 1'b0;
			dqs_oe_r  <= 1'b0;
		end else begin
			pwr_r     <= pwr_nxt;
			dp_r      <= dp_nxt;
			mode_r    <= mode_nxt;
			open_r    <= open_nxt;
			row_r     <= row_nxt;
			bbank_r   <= bbank_nxt;
			bcol_r    <= bcol_nxt;
			ap_r      <= ap_nxt;
			beat_r    <= beat_nxt;
			wait_r    <= wait_nxt;
			mem_r     <= mem_nxt;
			refcnt_r  <= refcnt_nxt;
			dq_out_r  <= dq_out_nxt;
			dq_oe_r   <= dq_oe_nxt;
			dqs_out_r <= dqs_out_nxt;
			dqs_oe_r  <= dqs_oe_nxt;
		end
	end

	// =====================================
	// apb: one wait state, answer registered
	always_comb begin
		pready_nxt  = psel && penable && !pready_r;
		pslverr_nxt = 1'b0;
		prdata_nxt  = 32'h0;
		if (psel && penable && !pready_r) begin
			case (paddr)
				ddrdv_pkg::OFS_MODE: prdata_nxt = 32'(mode_r);
				ddrdv_pkg::OFS_STATUS: begin
					prdata_nxt[ddrdv_pkg::NBANK-1:0]     = open_r;
					prdata_nxt[ddrdv_pkg::STS_PWR +: 2]  = 2'(pwr_r);
					prdata_nxt[ddrdv_pkg::STS_BUSY]      = (dp_r != ddrdv_pkg::DP_IDLE);
				end
				ddrdv_pkg::OFS_REFCNT: prdata_nxt = 32'(refcnt_r);
				default: pslverr_nxt = 1'b1;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r  <= 32'h0;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	assign prdata  = prdata_r;
	assign pready  = pready_r;
	assign pslverr = pslverr_r;
	assign dq_out  = dq_out_r;
	assign dq_oe   = dq_oe_r;
	assign dqs_out = dqs_out_r;
	assign dqs_oe  = dqs_oe_r;
endmodule

// File: bench/ddrdv_assertions.sv
`timescale 1ns/10ps
// ==========================================
// bus and strobe checks
module ddrdv_chk #(
	parameter int ROW_KEEP = 2,
	parameter int COL_KEEP = 3
) (
	// apb
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// data pins
	input wire logic        dq_oe,
	input wire logic        dqs_out,
	input wire logic        dqs_oe
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_ready_wait: assert property ($rose(penable) && psel |=> pready)
		else $error("pready late");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_err_map: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08}))
		else $error("pslverr wrong for address");
	chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata not zero outside answer");
	chk_mode_rsvd: assert property (pready && !pwrite && paddr == 8'h00 |-> prdata[31:7] == 25'h0)
		else $error("mode upper bits not zero");
	chk_data_strobe: assert property (dq_oe |-> dqs_oe)
		else $error("data driven without strobe");
	chk_strobe_pre: assert property ($rose(dqs_oe) |-> !dqs_out)
		else $error("strobe preamble not low");
	chk_strobe_post: assert property ($fell(dq_oe) |-> dqs_oe ##[1:8] !dqs_oe)
		else $error("strobe postamble wrong");
	chk_beat_hold: assert property (dq_oe && $changed(dqs_out) |=> $stable(dqs_out) [*3])
		else $error("read beat shorter than half clock");
	cover property (pready && pslverr);
	cover property ($rose(dq_oe));
	cover property (pready && pwrite);
endmodule
bind ddrdv_top ddrdv_chk #(.ROW_KEEP(ROW_KEEP), .COL_KEEP(COL_KEEP)) u_chk (.pclk(pclk), .presetn(presetn),
	.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe));

// File: bench/ddrdv_host_model.sv
`timescale 1ns/10ps
// ==========================================
// memory controller model
module ddrdv_host_model (
	// clock and command
	output logic        ck,
	output logic        ck_n,
	output logic        cke,
	output logic        cs_n,
	output logic        ras_n,
	output logic        cas_n,
	output logic        we_n,
	output logic [1:0]  bank_select_lines,
	output logic [12:0] addr,
	// write data
	output logic        dm,
	output logic        dqs_in,
	output logic [7:0]  dq_in
);
	time t_edge;
	// clock runs free from time zero
	initial begin
		{ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, dm, dqs_in} = 9'h0FE;
		{bank_select_lines, addr, dq_in} = 23'h0;
		forever #100 {ck, ck_n} = {~ck, ck};
	end
	// set up at the falling edge, held to the next one since pins are seen late
	// one command per two link clocks keeps activate and row-cycle spacing
	task cmd(input logic c_cs_n, input logic c_cke, input logic [2:0] c, input logic [1:0] b,
		input logic [12:0] a);
		@(negedge ck);
		cs_n = c_cs_n;
		cke = c_cke;
		{ras_n, cas_n, we_n} = c;
		bank_select_lines = b;
		addr = a;
		@(posedge ck);
		t_edge = $time;
		@(negedge ck);
		cs_n = 1'b1;
		{ras_n, cas_n, we_n} = 3'h7;
		bank_select_lines = ~b;
		addr = ~a;
	endtask
	// strobe edge in the middle of each data eye; released lines flip
	task wburst(input logic [31:0] d, input logic [3:0] m);
		int i;
		#50;
		for (i = 0; i < 4; i++) begin
			dq_in = d[8*i+:8];
			dm = m[i];
			#50 dqs_in = ~dqs_in;
			#50;
		end
		dq_in = ~dq_in;
		dm = ~dm;
	endtask
endmodule

// File: bench/tb_top.sv
`timescale 1ns/10ps
// ==========================================
// testbench
module tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, erv, dqs_q;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic        ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, dm, dqs_in, dq_oe, dqs_out, dqs_oe;
	logic [1:0]  bsl;
	logic [12:0] addr;
	logic [7:0]  dq_in, dq_out;
	logic [7:0]  rd_q[$];
	int          error_cnt, n_tests;
	time         t_first;
	ddrdv_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ck(ck),
		.ck_n(ck_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
		.bank_select_lines(bsl), .addr(addr), .dm(dm), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
		.dqs_in(dqs_in), .dqs_out(dqs_out), .dqs_oe(dqs_oe));
	ddrdv_host_model host (.ck(ck), .ck_n(ck_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
		.we_n(we_n), .bank_select_lines(bsl), .addr(addr), .dm(dm), .dqs_in(dqs_in), .dq_in(dq_in));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	// read beats are taken where the strobe turns
	always @(posedge pclk) begin
		dqs_q <= dqs_out;
		if (dq_oe && dqs_oe && dqs_out !== dqs_q) begin
			if (rd_q.size() == 0)
				t_first = $time;
			rd_q.push_back(dq_out);
		end
	end
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic er);
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= wr;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0, rdv, erv);
		chk(nm, rdv, exp);
	endtask
	task getn(input int k);
		int n;
		n = 0;
		while (rd_q.size() < k && n < 400) begin
			@(posedge pclk);
			n++;
		end
		chk("read beats", rd_q.size(), k);
	endtask
	task rdb(input logic [6:0] m, input logic [12:0] col, input int k);
		apb(1'b1, 8'h00, {25'h0, m}, rdv, erv);
		rd_q.delete();
		host.cmd(1'b0, 1'b1, ddrdv_pkg::CMD_RD, 2'h0, col);
		getn(k);
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// no test should need more than a few tens of microseconds
	initial begin
		#500000;
		error_cnt++;
		complete_run();
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = 43'h0;
		presetn = 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rchk("mode", 8'h00, 32'h22);
		rchk("status", 8'h04, 32'h0);
		rchk("refcnt", 8'h08, 32'h0);
		apb(1'b1, 8'h0C, 32'h1, rdv, erv);
		chk("slverr", {31'h0, erv}, 32'h1);
		apb(1'b1, 8'h04, 32'hF, rdv, erv);
		rchk("status ro", 8'h04, 32'h0);
		$display("test registers done");
		host.cmd(1'b0, 1'b1, ddrdv_pkg::CMD_ACT, 2'h1, 13'h0);
		rchk("act", 8'h04, 32'h2);
		host.cmd(1'b1, 1'b1, ddrdv_pkg::CMD_ACT, 2'h2, 13'h0);
		rchk("deselect", 8'h04, 32'h2);
		host.cmd(1'b0, 1'b1, ddrdv_pkg::CMD_PRE, 2'h0, 13'h0400);
		rchk("pre all", 8'h04, 32'h0);
		host.cmd(1'b0, 1'b1, ddrdv_pkg::CMD_REF, 2'h0, 13'h0);
		rchk("refresh", 8'h08, 32'h1);
		host.cmd(1'b0, 1'b1, ddrdv_pkg::CMD_ACT, 2'h3, 13'h0);
		host.cmd(1'b0, 1'b0, 3'h7, 2'h0, 13'h0);
		rchk("act pdn", 8'h04, 32'h28);
		host.cmd(1'b0, 1'b1, 3'h7, 2'h0, 13'h0);
		rchk("pdn exit", 8'h04, 32'h08);
		host.cmd(1'b0, 1'b1, ddrdv_pkg::CMD_PRE, 2'h3, 13'h0);
		host.cmd(1'b0, 1'b0, ddrdv_pkg::CMD_REF, 2'h0, 13'h0);
		rchk("self ref", 8'h04, 32'h30);
		rchk("self ref cnt", 8'h08, 32'h2);
		host.cmd(1'b0, 1'b1, 3'h7, 2'h0, 13'h0);
		rchk("self exit", 8'h04, 32'h0);
		host.cmd(1'b0, 1'b1, ddrdv_pkg::CMD_MRS, 2'h0, 13'h0031);
		rchk("mrs", 8'h00, 32'h31);
		host.cmd(1'b0, 1'b1, ddrdv_pkg::CMD_MRS, 2'h1, 13'h0022);
		rchk("ext mrs", 8'h00, 32'h31);
		apb(1'b1, 8'h00, 32'h22, rdv, erv);
		$display("test commands done");
		host.cmd(1'b0, 1'b1, ddrdv_pkg::CMD_ACT, 2'h0, 13'h0);
		host.cmd(1'b0, 1'b1, ddrdv_pkg::CMD_WR, 2'h0, 13'h0);
		host.wburst(32'h44332211, 4'h0);
		host.cmd(1'b0, 1'b1, ddrdv_pkg::CMD_WR, 2'h0, 13'h0);
		host.wburst(32'hA4A3A2A1, 4'h2);
		rdb(7'h22, 13'h0, 4);
		chk("rd bl4", {rd_q[3], rd_q[2], rd_q[1], rd_q[0]}, 32'hA4A322A1);
		chk("cl2", 32'((t_first - host.t_edge) / 200), {29'h0, ddrdv_pkg::HALVES_2 >> 1});
		rdb(7'h3A, 13'h1, 4);
		chk("rd inter", {rd_q[3], rd_q[2], rd_q[1], rd_q[0]}, 32'hA3A4A122);
		chk("cl3", 32'((t_first - host.t_edge) / 200), {29'h0, ddrdv_pkg::HALVES_3 >> 1});
		rdb(7'h21, 13'h2, 2);
		chk("rd bl2", {16'h0, rd_q[1], rd_q[0]}, 32'hA4A3);
		rdb(7'h63, 13'h0, 8);
		chk("rd bl8", {rd_q[3], rd_q[2], rd_q[1], rd_q[0]}, 32'hA4A322A1);
		chk("bl8 beats", rd_q.size(), 32'h8);
		chk("cl25", 32'((t_first - host.t_edge) / 100), 32'(ddrdv_pkg::HALVES_25));
		$display("test data done");
		complete_run();
	end
endmodule
